/* File: common/sar_readout_defines.vh */
`ifndef SAR_READOUT_DEFINES_VH
`define SAR_READOUT_DEFINES_VH

// Result word
`define WORD_BITS          15
`define BIT_CNT_W          4
`define BIT_CNT_LAST       4'hE
`define BIT_CNT_ZERO       4'h0

// Timing figures in ns, clock period in ns
`define CLK_PERIOD_NS      25
`define CONVERSION_DELAY_NS 220
// Least time rounds up to whole cycles
`define CONV_CYCLES        ((`CONVERSION_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CNT_W         4
`define CONV_CNT_ZERO      4'h0

// Signalling modes
`define MODE_CMOS          2'h0
`define MODE_LVDS          2'h1
`define MODE_LVDS_LP       2'h2

// Synchroniser reset level
`define SYNC_IDLE_HIGH     1'b1
`define SYNC_IDLE_LOW      1'b0

`endif

/* File: verilog/pin_sync.v */
`timescale 1ns/1ps
// Three-stage pin synchroniser; output changes once stages two and three agree
module pin_sync #(
    parameter RESET_VAL = 1'b0
) (
    input  wire ref_clk,
    input  wire rst,
    input  wire pin_in,
    output reg  level_out
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;

    // Shift chain and filtered level
    always @(posedge ref_clk) begin
        if (rst) begin
            s1_ff     <= RESET_VAL;
            s2_ff     <= RESET_VAL;
            s3_ff     <= RESET_VAL;
            level_out <= RESET_VAL;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                level_out <= s3_ff;
            end
        end
    end
endmodule

/* File: verilog/sar_adc_serial_readout.v */
`timescale 1ns/1ps
// Behaviour
// [R1] Falling convert strobe ends acquisition and starts a conversion.
// [R2] Host keeps shift clock quiet 220 ns after strobe falls.
// [R3] Result leaves MSB first, one bit per shift clock falling edge.
// [R4] Host shift clock period at least 15.6 ns, phases at least 5 ns.
// [R5] Data output driven promptly after strobe falls.
// [R6] Data output released promptly after strobe rises.
// [R7] Host may raise strobe any time after its last clock edge.
// [R8] Result bits shift only after the conversion time, at least 220 ns.
// [R9] Mode pin: low CMOS, high LVDS, floating low-power LVDS.
// [R10] Convert strobe behaves the same in every signalling mode.
// [R11] CMOS mode drives only positive data pin; negative pins unused.
// [R12] LVDS modes drive result differentially on both data pins.
// [R13] Host drives differential shift clock in LVDS modes.
// [R14] Each conversion yields a 15-bit output word.
// [R15] Output word is two's complement of the differential input.
// [R16] Shifted bits belong to the conversion of this same strobe.
// [R17] Host captures each bit on the following falling edge, 15 per frame.
//
`include "sar_readout_defines.vh"
module sar_adc_serial_readout (
    input  wire                   ref_clk,
    input  wire                   rst,
    input  wire                   conv_start_n,
    input  wire                   shift_clk_p,
    input  wire                   shift_clk_n,
    input  wire                   mode_pin_in,
    input  wire                   mode_pin_pullup_in,
    input  wire [`WORD_BITS-1:0]  sample_code,
    output reg                    sample_take,
    output reg                    data_out_p,
    output reg                    data_out_n,
    output reg                    data_out_p_oe,
    output reg                    data_out_n_oe,
    output reg  [1:0]             io_mode,
    output reg                    converting,
    output reg                    low_power_lvds
);

    localparam [1:0] ST_ACQ  = 2'h0;
    localparam [1:0] ST_CONV = 2'h1;
    localparam [1:0] ST_SHIFT = 2'h2;
    localparam integer CONV_LAST_INT = `CONV_CYCLES - 1;
    localparam [`CONV_CNT_W-1:0] CONV_LAST = CONV_LAST_INT[`CONV_CNT_W-1:0];

    wire conv_n_s;
    wire sck_p_s;
    wire sck_n_s;
    wire mode_a_s;
    wire mode_b_s;

    reg  [1:0]            state_ff;
    reg  [1:0]            nxt_state;
    reg                   conv_n_d_ff;
    reg                   sck_d_ff;
    reg  [`CONV_CNT_W-1:0] conv_cnt_ff;
    reg  [`BIT_CNT_W-1:0]  bit_cnt_ff;
    reg  [`WORD_BITS-1:0]  shreg_ff;
    reg                   drive_ff;
    reg                   sck_eff;

    // Pin synchronisers
    pin_sync #(.RESET_VAL(`SYNC_IDLE_HIGH)) u_sync_conv (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .pin_in    (conv_start_n),
        .level_out (conv_n_s)
    );
    pin_sync #(.RESET_VAL(`SYNC_IDLE_LOW)) u_sync_sckp (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .pin_in    (shift_clk_p),
        .level_out (sck_p_s)
    );
    pin_sync #(.RESET_VAL(`SYNC_IDLE_HIGH)) u_sync_sckn (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .pin_in    (shift_clk_n),
        .level_out (sck_n_s)
    );
    // Mode pin sampled twice: with weak pull-down and with weak pull-up
    pin_sync #(.RESET_VAL(`SYNC_IDLE_LOW)) u_sync_mode_a (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .pin_in    (mode_pin_in),
        .level_out (mode_a_s)
    );
    pin_sync #(.RESET_VAL(`SYNC_IDLE_LOW)) u_sync_mode_b (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .pin_in    (mode_pin_pullup_in),
        .level_out (mode_b_s)
    );

    // Three-state mode decode
    always @(posedge ref_clk) begin
        if (rst) begin
            io_mode        <= `MODE_CMOS;
            low_power_lvds <= 1'b0;
        end else if (!mode_a_s && !mode_b_s) begin
            io_mode        <= `MODE_CMOS; // R9
            low_power_lvds <= 1'b0;
        end else if (mode_a_s && mode_b_s) begin
            io_mode        <= `MODE_LVDS; // R9
            low_power_lvds <= 1'b0;
        end else begin
            io_mode        <= `MODE_LVDS_LP; // R9
            low_power_lvds <= 1'b1;
        end
    end

    // Effective shift clock: single-ended in CMOS, differential otherwise
    always @* begin
        if (io_mode == `MODE_CMOS) begin
            sck_eff = sck_p_s; // R11
        end else begin
            sck_eff = sck_p_s & ~sck_n_s; // R13
        end
    end

    wire conv_fall = conv_n_d_ff & ~conv_n_s; // R1 R10
    wire conv_rise = ~conv_n_d_ff & conv_n_s;
    wire sck_fall  = sck_d_ff & ~sck_eff;

    // State transitions
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_ACQ: begin
                if (conv_fall) begin
                    nxt_state = ST_CONV; // R1
                end
            end
            ST_CONV: begin
                if (conv_rise) begin
                    nxt_state = ST_ACQ;
                end else if (conv_cnt_ff == CONV_LAST) begin
                    nxt_state = ST_SHIFT; // R8
                end
            end
            ST_SHIFT: begin
                if (conv_rise) begin
                    nxt_state = ST_ACQ; // R7
                end
            end
            default: begin
                nxt_state = ST_ACQ;
            end
        endcase
    end

    // Sequencer, conversion timer and shift register
    always @(posedge ref_clk) begin
        if (rst) begin
            state_ff    <= ST_ACQ;
            conv_n_d_ff <= 1'b1;
            sck_d_ff    <= 1'b0;
            conv_cnt_ff <= `CONV_CNT_ZERO;
            bit_cnt_ff  <= `BIT_CNT_ZERO;
            shreg_ff    <= {`WORD_BITS{1'b0}};
            drive_ff    <= 1'b0;
            sample_take <= 1'b0;
            converting  <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            conv_n_d_ff <= conv_n_s;
            sck_d_ff    <= sck_eff;
            sample_take <= 1'b0;
            if (conv_fall) begin
                drive_ff <= 1'b1; // R5
            end else if (conv_rise) begin
                drive_ff <= 1'b0; // R6
            end
            if (state_ff == ST_ACQ && conv_fall) begin
                conv_cnt_ff <= `CONV_CNT_ZERO;
                converting  <= 1'b1;
                sample_take <= 1'b1; // R1 R16
                // Capture two's complement code of this sample
                shreg_ff    <= sample_code; // R14 R15 R16
                bit_cnt_ff  <= `BIT_CNT_ZERO;
            end else if (state_ff == ST_CONV) begin
                conv_cnt_ff <= conv_cnt_ff + 1'b1; // R8
                if (nxt_state != ST_CONV) begin
                    converting <= 1'b0;
                end
            end else if (state_ff == ST_SHIFT && sck_fall && bit_cnt_ff != `BIT_CNT_LAST) begin
                // Next bit on each falling edge, MSB first
                shreg_ff   <= {shreg_ff[`WORD_BITS-2:0], 1'b0}; // R3
                bit_cnt_ff <= bit_cnt_ff + 1'b1;
            end
        end
    end

    // Output pins: MSB of shift register, differential outside CMOS
    always @(posedge ref_clk) begin
        if (rst) begin
            data_out_p    <= 1'b0;
            data_out_n    <= 1'b0;
            data_out_p_oe <= 1'b0;
            data_out_n_oe <= 1'b0;
        end else begin
            data_out_p    <= shreg_ff[`WORD_BITS-1]; // R3
            data_out_n    <= ~shreg_ff[`WORD_BITS-1]; // R12
            data_out_p_oe <= drive_ff; // R5 R6
            data_out_n_oe <= drive_ff & (io_mode != `MODE_CMOS); // R11 R12
        end
    end
endmodule

/* File: tb/readout_checker_assertions.sv */
`timescale 1ns/1ps
`include "sar_readout_defines.vh"
module readout_checker (
    input wire                 ref_clk,
    input wire                 rst,
    input wire                 conv_start_n,
    input wire                 mode_pin_in,
    input wire                 mode_pin_pullup_in,
    input wire [`WORD_BITS-1:0] sample_code,
    input wire                 sample_take,
    input wire                 data_out_p,
    input wire                 data_out_n,
    input wire                 data_out_p_oe,
    input wire                 data_out_n_oe,
    input wire [1:0]           io_mode,
    input wire                 converting,
    input wire                 low_power_lvds
);
    // All checks share the system clock and its reset
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_take_once: assert property (sample_take |=> !sample_take)
        else $error("capture pulse too long");
    a_take_time: assert property ($fell(conv_start_n) |-> ##[3:6] sample_take)
        else $error("capture pulse missing after strobe fall");
    a_start_oe: assert property ($fell(conv_start_n) |-> ##[3:8] data_out_p_oe)
        else $error("data output not driven after strobe fall");
    a_release_oe: assert property ($rose(conv_start_n) |-> ##[3:8] !data_out_p_oe)
        else $error("data output not released after strobe rise");
    a_conv_len: assert property ($rose(converting) |-> converting[*8] ##[1:3] !converting)
        else $error("conversion wait has wrong length");
    a_no_shift: assert property (converting && $past(converting) |=> $stable(data_out_p))
        else $error("data moved during conversion");
    a_msb_load: assert property ($rose(data_out_p_oe) |=> data_out_p == sample_code[`WORD_BITS-1])
        else $error("first bit is not the top bit");
    a_diff_pair: assert property (data_out_n_oe |-> data_out_n != data_out_p)
        else $error("negative data not inverse");
    a_cmos_single: assert property (io_mode == `MODE_CMOS |-> !data_out_n_oe)
        else $error("negative data driven in single-ended mode");
    a_mode_lvds: assert property ((mode_pin_in && mode_pin_pullup_in)[*8] |-> io_mode == `MODE_LVDS)
        else $error("mode pin high not decoded");
    a_mode_float: assert property ((!mode_pin_in && mode_pin_pullup_in)[*8]
        |-> io_mode == `MODE_LVDS_LP && low_power_lvds)
        else $error("floating mode pin not decoded");
endmodule
bind sar_adc_serial_readout readout_checker chk (
    .ref_clk            (ref_clk),
    .rst                (rst),
    .conv_start_n       (conv_start_n),
    .mode_pin_in        (mode_pin_in),
    .mode_pin_pullup_in (mode_pin_pullup_in),
    .sample_code        (sample_code),
    .sample_take        (sample_take),
    .data_out_p         (data_out_p),
    .data_out_n         (data_out_n),
    .data_out_p_oe      (data_out_p_oe),
    .data_out_n_oe      (data_out_n_oe),
    .io_mode            (io_mode),
    .converting         (converting),
    .low_power_lvds     (low_power_lvds)
);

/* File: tb/host_reader.sv */
`timescale 1ns/1ps
module host_reader (
    input  wire  ref_clk,
    output logic conv_start_n,
    output logic shift_clk_p,
    output logic shift_clk_n,
    input  wire  data_out_p,
    input  wire  data_out_p_oe
);
    // Idle: strobe high, shift clock parked low
    initial begin
        conv_start_n = 1'b1;
        shift_clk_p = 1'b0;
        shift_clk_n = 1'b0;
    end
    // Negative clock pin mirrors in LVDS, follows positive when unused
    task automatic clk_to(input logic v, input logic lvds);
        shift_clk_p = v;
        shift_clk_n = v ^ lvds;
    endtask
    // One frame: strobe, quiet wait, 15 captures, strobe rise
    task automatic frame(input logic lvds, output logic [14:0] word);
        @(negedge ref_clk) conv_start_n = 1'b0;
        repeat (12) @(negedge ref_clk);
        for (int i = 14; i >= 0; i--) begin
            clk_to(1'b1, lvds);
            repeat (4) @(negedge ref_clk);
            // Released pin reads as the inverse of the last bit
            word[i] = data_out_p_oe ? data_out_p : ~data_out_p;
            clk_to(1'b0, lvds);
            repeat (4) @(negedge ref_clk);
        end
        conv_start_n = 1'b1;
        repeat (12) @(negedge ref_clk);
    endtask
endmodule

/* File: tb/sar_adc_serial_readout_bench.sv */
`timescale 1ns/1ps
`include "sar_readout_defines.vh"
module sar_adc_serial_readout_bench;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        mode_pin_in = 1'b0;
    logic        mode_pin_pullup_in = 1'b0;
    logic [14:0] sample_code = 15'h0000;
    logic [14:0] word;
    wire         conv_start_n, shift_clk_p, shift_clk_n, sample_take, data_out_p, data_out_n;
    wire         data_out_p_oe, data_out_n_oe, converting, low_power_lvds;
    wire  [1:0]  io_mode;
    integer      bad_count = 0;
    integer      checks = 0;
    sar_adc_serial_readout uut (
        .ref_clk            (ref_clk),
        .rst                (rst),
        .conv_start_n       (conv_start_n),
        .shift_clk_p        (shift_clk_p),
        .shift_clk_n        (shift_clk_n),
        .mode_pin_in        (mode_pin_in),
        .mode_pin_pullup_in (mode_pin_pullup_in),
        .sample_code        (sample_code),
        .sample_take        (sample_take),
        .data_out_p         (data_out_p),
        .data_out_n         (data_out_n),
        .data_out_p_oe      (data_out_p_oe),
        .data_out_n_oe      (data_out_n_oe),
        .io_mode            (io_mode),
        .converting         (converting),
        .low_power_lvds     (low_power_lvds)
    );
    host_reader host (
        .ref_clk       (ref_clk),
        .conv_start_n  (conv_start_n),
        .shift_clk_p   (shift_clk_p),
        .shift_clk_n   (shift_clk_n),
        .data_out_p    (data_out_p),
        .data_out_p_oe (data_out_p_oe)
    );
    // Count and report one comparison
    task automatic check(input string what, input logic [14:0] exp, input logic [14:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize;
        if (bad_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Every mode in turn, two boundary codes and one mid-range code, mode settles 10 cycles before each frame
    task automatic scan_modes;
        logic [1:0]  pins [3] = '{2'b00, 2'b11, 2'b10};
        logic [14:0] codes [3] = '{15'h4000, 15'h3FFF, 15'h1A5C};
        for (int m = 0; m < 3; m++) begin
            {mode_pin_pullup_in, mode_pin_in} = pins[m];
            sample_code = codes[m];
            repeat (10) @(negedge ref_clk);
            check("io_mode", 15'(m), 15'(io_mode));
            check("low_power_lvds", 15'(m == 2), 15'(low_power_lvds));
            host.frame(m != 0, word);
            check("word", codes[m], word);
            check("oe after rise", 15'h0, 15'({data_out_p_oe, data_out_n_oe}));
        end
    endtask
    // Pins mid-conversion in LVDS mode
    task automatic conv_wait;
        {mode_pin_pullup_in, mode_pin_in} = 2'b11;
        sample_code = 15'h5555;
        repeat (10) @(negedge ref_clk);
        fork
            host.frame(1'b1, word);
            begin
                repeat (6) @(negedge ref_clk);
                check("sample_take", 15'h1, 15'(sample_take));
                repeat (4) @(negedge ref_clk);
                check("oe pair", 15'h3, 15'({data_out_p_oe, data_out_n_oe}));
                check("converting", 15'h1, 15'(converting));
                check("msb pair", 15'h2, 15'({data_out_p, data_out_n}));
            end
        join
        check("word lvds", 15'h5555, word);
    endtask
    // Free-running system clock
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Hang guard
    initial begin
        #200000;
        bad_count++;
        summarize;
    end
    // Main sequence
    initial begin
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        repeat (6) @(negedge ref_clk);
        scan_modes;
        conv_wait;
        summarize;
    end
endmodule
